// ==== design/count_clock_select.sv ====
// count clock selection from the prescaled clock enables
`timescale 1ns/10ps
module count_clock_select (
   input wire logic [3:0] prescale_en,
   input wire logic [1:0] clock_select,
   input wire logic wide_select,
   input wire logic gate,
   output logic tick
);
   import timer_channel_pkg::*;

   // prescaled clocks 2 and 3 exist only on wide-select channels; elsewhere no tick
   always_comb begin
      tick = 1'b0;
      case (clock_select)
         CKS_0: tick = prescale_en[0];
         CKS_1: tick = prescale_en[1];
         CKS_2: tick = wide_select & prescale_en[2];
         CKS_3: tick = wide_select & prescale_en[3];
         default: tick = 1'b0;
      endcase
      tick = tick & gate;
   end
endmodule

// ==== design/interval_timer_channel.sv ====
// interval timer / square wave channel with register port and output pin
//
// Functional notes
// - mode field 000 runs the channel as periodic interval timer
// - start-behaviour bit 1 gives interrupt and toggle at start, 0 neither
// - start-trigger field 000 accepts only the software start trigger
// - split bit on channels 1 and 3: 0 one 16-bit, 1 two 8-bit timers
// - master bit 0 on channels 2, 4, 6 means independent operation
// - count-clock source bit 0 clocks counter from channel operation clock
// - clock field 00 and 10 pick clocks 0 and 1; 01, 11 only channels 1, 3
// - output bit drives the channel output: 0 low, 1 high
// - output enable 1 lets counter change output; 0 only software writes
// - without peripheral enable, clock stopped and register writes ignored
// - pin high impedance until port is output with latch 0, then shows output bit
// - writing 1 to start trigger sets enable status and starts counting
// - start trigger bit clears itself and always reads 0
// - start copies reload into count; start interrupt and toggle if bit set
// - counter decrements per count clock, at zero reloads, interrupts, toggles
// - count readable anytime; reload, output, enable writable while running
// - stop trigger self-clears, clears status, holds count and output
// - after stop with enable cleared, pin follows written output bit
// - interrupt period is count clock times reload plus one, output toggles
// - new reload takes effect only at the next reload
`timescale 1ns/10ps
module interval_timer_channel #(
   parameter int channel_index = 1
) (
   input wire logic mclk,
   input wire logic srst,
   input wire timer_channel_pkg::reg_req_type req,
   input wire logic [3:0] prescale_en,
   input wire timer_channel_pkg::port_setup_type port_setup,
   output logic [timer_channel_pkg::DATA_W-1:0] rdata,
   output logic channel_interrupt,
   output logic channel_interrupt_high,
   output logic channel_active,
   output logic pin_out,
   output logic pin_oe_n
);
   import timer_channel_pkg::*;

   // ----------------------------------------------------------------
   // channel capabilities
   // ----------------------------------------------------------------
   localparam logic split_capable = SPLIT_CHANNELS[channel_index];
   localparam logic master_capable = MASTER_CHANNELS[channel_index];
   // split/master bit is fixed to zero on channels that have neither
   localparam logic [DATA_W-1:0] mode_mask =
      (split_capable | master_capable) ? MODE_WRITE_MASK : (MODE_WRITE_MASK & ~MS_MASK);

   chan_state_type cur;
   chan_state_type next_state;

   logic tick;
   logic split_mode;
   logic clock_gate;
   logic wr_ok;
   logic start_hit;
   logic stop_hit;

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   // register writes only land once the peripheral enable is set
   assign wr_ok = req.wr & cur.periph_en;
   // only the software trigger is a start source, only in interval mode
   assign start_hit = wr_ok && (req.addr == OFS_START) && req.wdata[0]
      && (cur.mode[STS_HI:STS_LO] == TRIG_SOFTWARE)
      && (cur.mode[MD_HI:MD_LO] == MODE_INTERVAL);
   assign stop_hit = wr_ok && (req.addr == OFS_STOP) && req.wdata[0];
   // split only on channels that have the bit; master bit 0 needs nothing extra
   assign split_mode = split_capable & cur.mode[MS_POS];
   // a pin-sourced count clock is not supported, so it never ticks
   assign clock_gate = cur.periph_en & (cur.mode[CCS_POS] == CCS_OP_CLOCK);

   count_clock_select u_clock_select (
      .prescale_en(prescale_en),
      .clock_select(cur.mode[CKS_HI:CKS_LO]),
      .wide_select(split_capable),
      .gate(clock_gate),
      .tick(tick)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic toggle;
      toggle = 1'b0;
      next_state = cur;
      next_state.irq = 1'b0;
      next_state.irq_high = 1'b0;
      next_state.rdata = DATA_ZERO;

      // counting, frozen in the cycle of a stop so count and output hold
      if (!stop_hit) begin
         case (cur.run_state)
            stopped: begin
               next_state.run_state = stopped;
            end
            load_pending: begin
               if (tick) begin
                  next_state.count = cur.reload;
                  next_state.run_state = counting;
                  if (cur.mode[MD_START_POS]) begin
                     next_state.irq = 1'b1;
                     next_state.irq_high = split_mode;
                     toggle = 1'b1;
                  end
               end
            end
            counting: begin
               if (tick && !split_mode) begin
                  // reload is sampled only at a wrap or at the start load, so mid-period writes wait
                  if (cur.count == DATA_ZERO) begin
                     next_state.count = cur.reload;
                     next_state.irq = 1'b1;
                     toggle = 1'b1;
                  end else begin
                     next_state.count = cur.count - COUNT_STEP;
                  end
               end else if (tick) begin
                  // two independent 8-bit timers, output follows the low one
                  if (cur.count[7:0] == BYTE_ZERO) begin
                     next_state.count[7:0] = cur.reload[7:0];
                     next_state.irq = 1'b1;
                     toggle = 1'b1;
                  end else begin
                     next_state.count[7:0] = cur.count[7:0] - BYTE_STEP;
                  end
                  if (cur.count[15:8] == BYTE_ZERO) begin
                     next_state.count[15:8] = cur.reload[15:8];
                     next_state.irq_high = 1'b1;
                  end else begin
                     next_state.count[15:8] = cur.count[15:8] - BYTE_STEP;
                  end
               end
            end
            default: begin
               next_state.run_state = stopped;
            end
         endcase
      end

      // counter-driven output change only with the output enabled
      if (toggle && cur.out_en) begin
         next_state.out_bit = ~cur.out_bit;
      end

      // register writes; trigger bits are not stored, so they read 0
      if (wr_ok) begin
         if (req.addr == OFS_MODE) begin
            next_state.mode = req.wdata & mode_mask;
         end else if (req.addr == OFS_RELOAD) begin
            next_state.reload = req.wdata;
         end else if (req.addr == OFS_OUTPUT) begin
            if (!cur.out_en) begin
               next_state.out_bit = req.wdata[0];
            end
         end else if (req.addr == OFS_OUT_ENABLE) begin
            next_state.out_en = req.wdata[0];
         end else if (req.addr == OFS_OUT_LEVEL) begin
            next_state.out_level = req.wdata[0];
         end else if (req.addr == OFS_OUT_KIND) begin
            next_state.out_kind = req.wdata[0];
         end
      end

      // start restarts a running channel with a fresh load
      if (start_hit) begin
         next_state.active = 1'b1;
         next_state.run_state = load_pending;
      end else if (stop_hit) begin
         next_state.active = 1'b0;
         next_state.run_state = stopped;
      end

      // peripheral enable is always writable; clearing it initialises everything
      if (req.wr && (req.addr == OFS_PERIPH)) begin
         if (req.wdata[0]) begin
            next_state.periph_en = 1'b1;
         end else begin
            next_state = STATE_RESET;
         end
      end

      // read data stands in the cycle after the strobe
      if (req.rd) begin
         if (req.addr == OFS_MODE) begin
            next_state.rdata = cur.mode;
         end else if (req.addr == OFS_RELOAD) begin
            next_state.rdata = cur.reload;
         end else if (req.addr == OFS_COUNT) begin
            next_state.rdata = cur.count;
         end else if (req.addr == OFS_OUTPUT) begin
            next_state.rdata = {{(DATA_W-1){1'b0}}, cur.out_bit};
         end else if (req.addr == OFS_OUT_ENABLE) begin
            next_state.rdata = {{(DATA_W-1){1'b0}}, cur.out_en};
         end else if (req.addr == OFS_OUT_LEVEL) begin
            next_state.rdata = {{(DATA_W-1){1'b0}}, cur.out_level};
         end else if (req.addr == OFS_OUT_KIND) begin
            next_state.rdata = {{(DATA_W-1){1'b0}}, cur.out_kind};
         end else if (req.addr == OFS_STATUS) begin
            next_state.rdata = {{(DATA_W-1){1'b0}}, cur.active};
         end else if (req.addr == OFS_PERIPH) begin
            next_state.rdata = {{(DATA_W-1){1'b0}}, cur.periph_en};
         end else begin
            next_state.rdata = DATA_ZERO;
         end
      end

      // pin driven only once port is output with latch 0; polarity from level bit
      next_state.pin_oe_n = ~(port_setup.dir_output & ~port_setup.latch);
      next_state.pin_out = next_state.out_bit ^ next_state.out_level;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         cur <= STATE_RESET;
      end else begin
         cur <= next_state;
      end
   end

   // outputs straight from the state flip-flops
   assign rdata = cur.rdata;
   assign channel_interrupt = cur.irq;
   assign channel_interrupt_high = cur.irq_high;
   assign channel_active = cur.active;
   assign pin_out = cur.pin_out;
   assign pin_oe_n = cur.pin_oe_n;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   AST_START_SETS_ACTIVE: assert property (start_hit |=> cur.active && cur.run_state == load_pending)
      else $error("start trigger did not set enable status");
   AST_TRIGGER_READS_ZERO: assert property (req.rd && (req.addr == OFS_START || req.addr == OFS_STOP)
      |=> rdata == DATA_ZERO)
      else $error("trigger bit read back nonzero");
   AST_LOAD_ON_START: assert property (cur.run_state == load_pending && tick && !stop_hit && !req.wr
      |=> cur.count == $past(cur.reload) && channel_interrupt == $past(cur.mode[MD_START_POS]))
      else $error("start load or start interrupt wrong");
   AST_DECREMENT: assert property (cur.run_state == counting && tick && !stop_hit && !split_mode
      && cur.count != DATA_ZERO |=> cur.count == $past(cur.count) - COUNT_STEP && !channel_interrupt)
      else $error("counter did not decrement by one");
   AST_WRAP: assert property (cur.run_state == counting && tick && !stop_hit && !split_mode
      && cur.count == DATA_ZERO |=> channel_interrupt && cur.count == $past(cur.reload))
      else $error("terminal count did not reload and interrupt");
   AST_TOGGLE_ON_IRQ: assert property (channel_interrupt && $past(cur.out_en)
      |-> cur.out_bit != $past(cur.out_bit))
      else $error("output did not toggle with interrupt");
   AST_STOP_HOLDS: assert property (stop_hit
      |=> !cur.active && cur.count == $past(cur.count) && cur.out_bit == $past(cur.out_bit))
      else $error("stop did not hold count and output");
   AST_DISABLED_IGNORES: assert property (!cur.periph_en |=> cur.mode == MODE_RESET && !cur.active)
      else $error("register changed while peripheral disabled");
   AST_PIN_ENABLE: assert property (pin_oe_n == !$past(port_setup.dir_output && !port_setup.latch))
      else $error("pin enable does not follow port setup");
   AST_SW_OUTPUT: assert property (wr_ok && req.addr == OFS_OUTPUT && !cur.out_en
      |=> cur.out_bit == $past(req.wdata[0]) && pin_out == ($past(req.wdata[0]) ^ cur.out_level))
      else $error("output bit write not reflected on pin");
   AST_NO_IRQ_STOPPED: assert property (cur.run_state == stopped && !start_hit |=> !channel_interrupt)
      else $error("interrupt while stopped");

   COV_WRAP: cover property (cur.run_state == counting && tick && cur.count == DATA_ZERO);
   COV_START_IRQ: cover property (cur.run_state == load_pending && tick && cur.mode[MD_START_POS]);
   COV_STOP: cover property (cur.active && stop_hit);
   COV_SPLIT_HIGH: cover property (channel_interrupt_high);
endmodule

// ==== design/timer_channel_pkg.sv ====
// shared constants, field layout and state types of the interval timer channel
package timer_channel_pkg;

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   localparam logic [ADDR_W-1:0] OFS_MODE = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_RELOAD = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_OUTPUT = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_OUT_ENABLE = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_OUT_LEVEL = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_OUT_KIND = 4'h6;
   localparam logic [ADDR_W-1:0] OFS_START = 4'h7;
   localparam logic [ADDR_W-1:0] OFS_STOP = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h9;
   localparam logic [ADDR_W-1:0] OFS_PERIPH = 4'ha;

   // ----------------------------------------------------------------
   // channel_mode_config field layout
   // ----------------------------------------------------------------
   localparam int CKS_HI = 15;
   localparam int CKS_LO = 14;
   localparam int CCS_POS = 12;
   localparam int MS_POS = 11;
   localparam int STS_HI = 10;
   localparam int STS_LO = 8;
   localparam int MD_HI = 3;
   localparam int MD_LO = 1;
   localparam int MD_START_POS = 0;
   localparam logic [DATA_W-1:0] MODE_WRITE_MASK = 16'hdfcf;
   localparam logic [DATA_W-1:0] MS_MASK = 16'h0800;

   localparam logic [2:0] MODE_INTERVAL = 3'h0;
   localparam logic [2:0] TRIG_SOFTWARE = 3'h0;
   localparam logic CCS_OP_CLOCK = 1'b0;
   localparam logic [1:0] CKS_0 = 2'h0;
   localparam logic [1:0] CKS_1 = 2'h2;
   localparam logic [1:0] CKS_2 = 2'h1;
   localparam logic [1:0] CKS_3 = 2'h3;

   // channels with a split bit, channels with a master bit (bit n = channel n)
   localparam logic [7:0] SPLIT_CHANNELS = 8'h0a;
   localparam logic [7:0] MASTER_CHANNELS = 8'h54;

   // ----------------------------------------------------------------
   // values
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
   localparam logic [DATA_W-1:0] COUNT_STEP = 16'h0001;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_STEP = 8'h01;
   localparam logic [DATA_W-1:0] MODE_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] RELOAD_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] COUNT_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // carriers and state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } reg_req_type;

   typedef struct packed {
      logic dir_output;
      logic latch;
   } port_setup_type;

   typedef enum logic [1:0] {stopped, load_pending, counting} run_state_type;

   typedef struct packed {
      logic periph_en;
      logic [DATA_W-1:0] mode;
      logic [DATA_W-1:0] reload;
      logic [DATA_W-1:0] count;
      logic out_bit;
      logic out_en;
      logic out_level;
      logic out_kind;
      logic active;
      run_state_type run_state;
      logic irq;
      logic irq_high;
      logic pin_out;
      logic pin_oe_n;
      logic [DATA_W-1:0] rdata;
   } chan_state_type;

   localparam chan_state_type STATE_RESET = '{
      periph_en: 1'b0, mode: MODE_RESET, reload: RELOAD_RESET, count: COUNT_RESET,
      out_bit: 1'b0, out_en: 1'b0, out_level: 1'b0, out_kind: 1'b0, active: 1'b0,
      run_state: stopped, irq: 1'b0, irq_high: 1'b0, pin_out: 1'b0, pin_oe_n: 1'b1,
      rdata: DATA_ZERO};

endpackage

// ==== tb/tb.sv ====
// self-checking bench of the interval timer channel
`timescale 1ns/10ps
module tb;
   import timer_channel_pkg::*;
   typedef struct packed {
      int stamp;
      logic pin;
   } irq_note_type;
   logic mclk;
   logic srst;
   reg_req_type req;
   logic [3:0] prescale_en;
   port_setup_type port_setup;
   logic [DATA_W-1:0] rdata;
   logic channel_interrupt;
   logic channel_interrupt_high;
   logic channel_active;
   logic pin_out;
   logic pin_oe_n;
   logic [DATA_W-1:0] rd_q[$];
   irq_note_type irq_q[$];
   int hi_q[$];
   int n_fail = 0;
   int comparisons = 0;
   int ncyc = 0;
   logic rd_seen = 1'b0;
   logic [DATA_W-1:0] r1;
   logic [DATA_W-1:0] r2;
   logic lvl;
   int t0;
   int t1;

   interval_timer_channel #(.channel_index(1)) i_interval_timer_channel (.mclk(mclk), .srst(srst), .req(req),
      .prescale_en(prescale_en), .port_setup(port_setup), .rdata(rdata), .channel_interrupt(channel_interrupt),
      .channel_interrupt_high(channel_interrupt_high), .channel_active(channel_active), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n));

   // 250 mhz clock
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // ----------------------------------------------------------------
   // compare and report
   // ----------------------------------------------------------------
   task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // register port driver, one idle edge after every strobe
   // ----------------------------------------------------------------
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge mclk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      t0 = ncyc;
      @(posedge mclk);
      req <= '0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      rd_q.push_back(exp);
      @(posedge mclk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: DATA_ZERO};
      @(posedge mclk);
      req <= '0;
   endtask

   // wait until only 'left' interrupt notes remain
   task automatic drain(input int left);
      int k;
      for (k = 0; k < 400 && irq_q.size() > left; k++) @(negedge mclk);
      if (irq_q.size() > left) begin
         n_fail++;
         $display("mismatch at %0t: interrupt wait timed out", $time);
         print_verdict();
      end
   endtask

   // returns at the falling edge inside the cycle in which the next interrupt stands
   task automatic wait_irq();
      int k;
      for (k = 0; k < 400; k++) begin
         @(negedge mclk);
         if (channel_interrupt === 1'b1) break;
      end
      if (k == 400) begin
         n_fail++;
         $display("mismatch at %0t: interrupt edge timed out", $time);
         print_verdict();
      end
   endtask

   // ----------------------------------------------------------------
   // monitor: read data and interrupts against the noted expectations
   // ----------------------------------------------------------------
   always @(posedge mclk) rd_seen <= req.rd;

   // negedge sampling keeps clear of the launching edge
   initial begin
      irq_note_type n;
      forever begin
         @(negedge mclk);
         ncyc++;
         if (rd_seen === 1'b1 && rd_q.size() > 0) begin
            check_word(rdata, rd_q.pop_front(), "read data");
         end
         if (channel_interrupt === 1'b1) begin
            if (irq_q.size() == 0) begin
               check_bit(1'b1, 1'b0, "unexpected interrupt");
            end else begin
               n = irq_q.pop_front();
               check_word(16'(ncyc), 16'(n.stamp), "interrupt time");
               check_bit(pin_out, n.pin, "pin at interrupt");
            end
         end
         if (channel_interrupt_high === 1'b1) begin
            if (hi_q.size() == 0) begin
               check_bit(1'b1, 1'b0, "unexpected upper interrupt");
            end else begin
               check_word(16'(ncyc), 16'(hi_q.pop_front()), "upper interrupt time");
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      srst = 1'b1;
      req = '0;
      prescale_en = 4'h0;
      port_setup = '0;
      void'($urandom(32'h6fa1));
      r1 = 16'(3 + $urandom % 5);
      r2 = 16'(3 + $urandom % 5);
      lvl = 1'($urandom);
      repeat (20) @(posedge mclk);
      srst <= 1'b0;
      prescale_en <= 4'h1;
      // writes before the peripheral enable are dropped
      wr(OFS_RELOAD, 16'h0005);
      rd(OFS_RELOAD, DATA_ZERO);
      check_bit(pin_oe_n, 1'b1, "pin released before port setup");
      wr(OFS_PERIPH, 16'h0001);
      rd(OFS_MODE, MODE_RESET);
      rd(OFS_STATUS, DATA_ZERO);
      rd(4'hc, DATA_ZERO);
      port_setup <= '{dir_output: 1'b1, latch: 1'b0};
      wr(OFS_OUT_ENABLE, DATA_ZERO);
      wr(OFS_OUTPUT, {15'h0000, lvl});
      repeat (2) @(posedge mclk);
      check_bit(pin_out, lvl, "preset output level");
      check_bit(pin_oe_n, 1'b0, "pin driven in output mode");
      // run with start interrupt, reload changed mid-run
      wr(OFS_MODE, 16'h0001);
      wr(OFS_OUT_KIND, DATA_ZERO);
      wr(OFS_OUT_LEVEL, DATA_ZERO);
      wr(OFS_RELOAD, r1);
      wr(OFS_OUT_ENABLE, 16'h0001);
      wr(OFS_START, 16'h0001);
      // start seen one edge after the strobe, load and start interrupt one edge later
      t1 = t0 + 3;
      for (int i = 0; i < 5; i++) begin
         if (i > 0) t1 = t1 + int'(i < 3 ? r1 : r2) + 1;
         irq_q.push_back('{stamp: t1, pin: (i % 2 == 0) ? ~lvl : lvl});
      end
      rd(OFS_START, DATA_ZERO);
      rd(OFS_STATUS, 16'h0001);
      drain(4);
      wait_irq();
      wr(OFS_RELOAD, r2);
      drain(1);
      wait_irq();
      // one more tick on the next edge, then the clock stops
      @(posedge mclk);
      prescale_en <= 4'h0;
      rd(OFS_COUNT, r2 - COUNT_STEP);
      // stop holds count and output while ticks keep coming
      wr(OFS_STOP, 16'h0001);
      prescale_en <= 4'h1;
      rd(OFS_STATUS, DATA_ZERO);
      rd(OFS_STOP, DATA_ZERO);
      repeat (20) @(posedge mclk);
      rd(OFS_COUNT, r2 - COUNT_STEP);
      check_bit(pin_out, ~lvl, "output held after stop");
      wr(OFS_OUT_ENABLE, DATA_ZERO);
      wr(OFS_OUTPUT, {15'h0000, lvl});
      repeat (2) @(posedge mclk);
      check_bit(pin_out, lvl, "software level after stop");
      // no start interrupt, clock 1 only, counter toggles blocked
      prescale_en <= 4'h2;
      wr(OFS_MODE, 16'h8000);
      wr(OFS_START, 16'h0001);
      irq_q.push_back('{stamp: t0 + 4 + int'(r2), pin: lvl});
      irq_q.push_back('{stamp: t0 + 5 + 2 * int'(r2), pin: lvl});
      drain(0);
      wr(OFS_STOP, 16'h0001);
      // split mode: low byte 3 wraps at the fourth tick, high byte 4 at the fifth
      prescale_en <= 4'h1;
      wr(OFS_MODE, 16'h0800);
      wr(OFS_RELOAD, 16'h0403);
      wr(OFS_START, 16'h0001);
      irq_q.push_back('{stamp: t0 + 7, pin: lvl});
      hi_q.push_back(t0 + 8);
      // stop lands before either byte timer wraps a second time
      repeat (6) @(posedge mclk);
      wr(OFS_STOP, 16'h0001);
      drain(0);
      check_word(16'(hi_q.size()), DATA_ZERO, "upper interrupt count");
      // a hardware start trigger source refuses the software start
      wr(OFS_MODE, 16'h0100);
      wr(OFS_START, 16'h0001);
      rd(OFS_STATUS, DATA_ZERO);
      // clearing the peripheral enable re-initialises the registers
      wr(OFS_PERIPH, DATA_ZERO);
      wr(OFS_PERIPH, 16'h0001);
      rd(OFS_RELOAD, RELOAD_RESET);
      repeat (4) @(posedge mclk);
      print_verdict();
   end
endmodule
